// *** core/sid_pkg.sv ***
package sid_pkg;

    // clock and blink timing
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned FAST_HALF_MS = 125;
    localparam int unsigned SLOW_HALF_MS = 1000;
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned SLOW_PER_FAST = SLOW_HALF_MS / FAST_HALF_MS;
    localparam int unsigned PHASE_W = $clog2(SLOW_PER_FAST) + 1;

    // channel counts
    localparam int unsigned NUM_TX = 4;
    localparam int unsigned NUM_REFL = 2;
    localparam int unsigned NUM_PORTS = 2;

    // register map, byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] LAMP_OFS = 4'h4;
    localparam logic [3:0] EVT_OFS = 4'h8;
    localparam logic [3:0] MASK_OFS = 4'hc;

    // control fields and reset value
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_TEST_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // lamp state fields
    localparam int unsigned LAMP_HEALTH_BIT = 0;
    localparam int unsigned LAMP_FAULT_BIT = 1;
    localparam int unsigned LAMP_TX_BIT = 2;
    localparam int unsigned LAMP_REFL_BIT = 3;
    localparam int unsigned LAMP_PORT_GREEN_BIT = 4;
    localparam int unsigned LAMP_PORT_RED_BIT = 6;
    localparam int unsigned LAMP_W = 8;

    // event fields
    localparam int unsigned EVT_REPLACE_BIT = 0;
    localparam int unsigned EVT_LOCATE_BIT = 1;
    localparam int unsigned EVT_REFL_BIT = 2;
    localparam int unsigned EVT_PORT_FAULT_BIT = 3;
    localparam int unsigned EVT_PORT_LOCK_BIT = 5;
    localparam int unsigned EVT_W = 7;
    localparam logic [6:0] EVT_RESET = 7'h00;
    localparam logic [6:0] MASK_RESET = 7'h00;

    // lamp drive modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ON = 2'b01,
        MODE_SLOW = 2'b10,
        MODE_FAST = 2'b11
    } sid_mode_t;

endpackage : sid_pkg

// *** core/sid_blink_gen.sv ***
`timescale 1ns/100ps
`default_nettype none

module sid_blink_gen #(
    parameter int unsigned TICK_CYCLES = sid_pkg::FAST_HALF_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // blink phases, high means lit
    output logic fast_phase,
    output logic slow_phase
);

    localparam int unsigned CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] div_reg;
    logic [sid_pkg::PHASE_W-1:0] phase_reg;
    logic tick;

    assign tick = (div_reg == TICK_LAST);

    ////////////////////////////////////////////////////////////////////////
    // divider producing one tick per fast half period
    always_ff @(posedge mclk) begin
        if (srst || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // shared phase counter, starts dark after reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            phase_reg <= '0;
        end else if (tick) begin
            phase_reg <= phase_reg + 1'b1;
        end
    end

    // bit 0 toggles each tick, top bit after eight ticks
    assign fast_phase = phase_reg[0];
    assign slow_phase = phase_reg[sid_pkg::PHASE_W-1];

endmodule : sid_blink_gen

`default_nettype wire

// *** core/sid_status_lamps.sv ***
// Overview of operation
// - health steady when powered but faulty
// - health dark without supply or drive fault
// - health slow blink in normal operation
// - health fast blink while loading or unstarted
// - fault lamp steady on replace alarm
// - fault lamp slow blink on locate alarm
// - fault lamp dark without alarm
// - activity steady with tx while running, or while loading before start
// - activity slow blink with tx disabled while running
// - reflection lamp steady while any reflection alarm
// - port lamp green while link good
// - port lamp red on module fault
// - port lamp red blink on lock loss
// - port lamp dark when module absent
`timescale 1ns/100ps
`default_nettype none

module sid_status_lamps #(
    parameter int unsigned TICK_CYCLES = sid_pkg::FAST_HALF_CYC,
    parameter int unsigned NUM_TX = sid_pkg::NUM_TX,
    parameter int unsigned NUM_REFL = sid_pkg::NUM_REFL
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // unit health conditions
    input wire logic power_ok,
    input wire logic drive_fault,
    input wire logic unit_fault,
    input wire logic sw_loading,
    input wire logic unit_started,
    // alarm conditions
    input wire logic replace_alarm,
    input wire logic locate_alarm,
    input wire logic [NUM_TX-1:0] tx_enable,
    input wire logic [NUM_REFL-1:0] reflection_alarm,
    // fronthaul port conditions
    input wire logic [sid_pkg::NUM_PORTS-1:0] module_present,
    input wire logic [sid_pkg::NUM_PORTS-1:0] module_powered,
    input wire logic [sid_pkg::NUM_PORTS-1:0] module_fault,
    input wire logic [sid_pkg::NUM_PORTS-1:0] lock_lost,
    input wire logic [sid_pkg::NUM_PORTS-1:0] link_up,
    // lamps, high means lit
    output logic health_lamp,
    output logic fault_lamp,
    output logic tx_activity_lamp,
    output logic reflection_alarm_lamp,
    output logic fronthaul_port0_lamp_green,
    output logic fronthaul_port0_lamp_red,
    output logic fronthaul_port1_lamp_green,
    output logic fronthaul_port1_lamp_red,
    // interrupt
    output logic irq
);

    // port count shorthand
    localparam int unsigned NP = sid_pkg::NUM_PORTS;

    // blink phases, control, events and lamp state
    logic fast_phase;
    logic slow_phase;
    logic [1:0] ctrl_reg;
    logic [sid_pkg::EVT_W-1:0] evt_reg;
    logic [sid_pkg::EVT_W-1:0] evt_next;
    logic [sid_pkg::EVT_W-1:0] mask_reg;
    logic [sid_pkg::EVT_W-1:0] cond_now;
    logic [sid_pkg::EVT_W-1:0] cond_reg;
    logic [31:0] rdata_next;
    logic [sid_pkg::LAMP_W-1:0] lamp_reg;
    logic [sid_pkg::LAMP_W-1:0] lamp_next;

    // per lamp drive modes
    sid_pkg::sid_mode_t health_mode;
    sid_pkg::sid_mode_t fault_mode;
    sid_pkg::sid_mode_t tx_mode;
    sid_pkg::sid_mode_t refl_mode;
    sid_pkg::sid_mode_t red_mode [NP];
    logic [NP-1:0] green_on;
    logic running;

    ////////////////////////////////////////////////////////////////////////
    // shared blink timing
    sid_blink_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_blink (
        .mclk(mclk),
        .srst(srst),
        .fast_phase(fast_phase),
        .slow_phase(slow_phase)
    );

    // turns a drive mode into a lamp level
    function automatic logic mode_level(sid_pkg::sid_mode_t m, logic slow, logic fast);
        logic lvl;
        lvl = 1'b0;
        case (m)
            sid_pkg::MODE_OFF: lvl = 1'b0;
            sid_pkg::MODE_ON: lvl = 1'b1;
            sid_pkg::MODE_SLOW: lvl = slow;
            sid_pkg::MODE_FAST: lvl = fast;
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction : mode_level

    ////////////////////////////////////////////////////////////////////////
    // health lamp, dark conditions take priority
    assign running = power_ok && unit_started && !unit_fault && !sw_loading;

    always_comb begin
        if (!power_ok || drive_fault) begin
            health_mode = sid_pkg::MODE_OFF;
        end else if (sw_loading || !unit_started) begin
            health_mode = sid_pkg::MODE_FAST;
        end else if (unit_fault) begin
            health_mode = sid_pkg::MODE_ON;
        end else begin
            health_mode = sid_pkg::MODE_SLOW;
        end
    end

    // fault lamp, replacement outranks location
    always_comb begin
        if (replace_alarm) begin
            fault_mode = sid_pkg::MODE_ON;
        end else if (locate_alarm) begin
            fault_mode = sid_pkg::MODE_SLOW;
        end else begin
            fault_mode = sid_pkg::MODE_OFF;
        end
    end

    // transmit activity lamp
    always_comb begin
        if (running && (|tx_enable)) begin
            tx_mode = sid_pkg::MODE_ON;
        end else if (power_ok && sw_loading && !unit_started) begin
            tx_mode = sid_pkg::MODE_ON;
        end else if (running) begin
            tx_mode = sid_pkg::MODE_SLOW;
        end else begin
            tx_mode = sid_pkg::MODE_OFF;
        end
    end

    // reflection lamp
    always_comb begin
        if (|reflection_alarm) begin
            refl_mode = sid_pkg::MODE_ON;
        end else begin
            refl_mode = sid_pkg::MODE_OFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per port bicolour lamp decode
    generate
        for (genvar p = 0; p < NP; p++) begin : g_port
            always_comb begin
                green_on[p] = 1'b0;
                if (!module_present[p] || !module_powered[p]) begin
                    red_mode[p] = sid_pkg::MODE_OFF;
                end else if (module_fault[p]) begin
                    red_mode[p] = sid_pkg::MODE_ON;
                end else if (lock_lost[p]) begin
                    red_mode[p] = sid_pkg::MODE_SLOW;
                end else begin
                    red_mode[p] = sid_pkg::MODE_OFF;
                    green_on[p] = link_up[p];
                end
            end

            assign lamp_next[sid_pkg::LAMP_PORT_GREEN_BIT + p] =
                ctrl_reg[sid_pkg::CTRL_TEST_BIT] ||
                (ctrl_reg[sid_pkg::CTRL_ENABLE_BIT] && green_on[p]);
            assign lamp_next[sid_pkg::LAMP_PORT_RED_BIT + p] =
                ctrl_reg[sid_pkg::CTRL_TEST_BIT] ||
                (ctrl_reg[sid_pkg::CTRL_ENABLE_BIT] &&
                 mode_level(red_mode[p], slow_phase, fast_phase));
            assign cond_now[sid_pkg::EVT_PORT_FAULT_BIT + p] =
                module_present[p] && module_powered[p] && module_fault[p];
            assign cond_now[sid_pkg::EVT_PORT_LOCK_BIT + p] =
                module_present[p] && module_powered[p] && lock_lost[p];
        end
    endgenerate

    // single lamps with enable and test override
    assign lamp_next[sid_pkg::LAMP_HEALTH_BIT] =
        ctrl_reg[sid_pkg::CTRL_TEST_BIT] ||
        (ctrl_reg[sid_pkg::CTRL_ENABLE_BIT] && mode_level(health_mode, slow_phase, fast_phase));
    assign lamp_next[sid_pkg::LAMP_FAULT_BIT] =
        ctrl_reg[sid_pkg::CTRL_TEST_BIT] ||
        (ctrl_reg[sid_pkg::CTRL_ENABLE_BIT] && mode_level(fault_mode, slow_phase, fast_phase));
    assign lamp_next[sid_pkg::LAMP_TX_BIT] =
        ctrl_reg[sid_pkg::CTRL_TEST_BIT] ||
        (ctrl_reg[sid_pkg::CTRL_ENABLE_BIT] && mode_level(tx_mode, slow_phase, fast_phase));
    assign lamp_next[sid_pkg::LAMP_REFL_BIT] =
        ctrl_reg[sid_pkg::CTRL_TEST_BIT] ||
        (ctrl_reg[sid_pkg::CTRL_ENABLE_BIT] && mode_level(refl_mode, slow_phase, fast_phase));

    // lamp flops, all dark in reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            lamp_reg <= '0;
        end else begin
            lamp_reg <= lamp_next;
        end
    end

    // lamp pins straight from the flops
    assign health_lamp = lamp_reg[sid_pkg::LAMP_HEALTH_BIT];
    assign fault_lamp = lamp_reg[sid_pkg::LAMP_FAULT_BIT];
    assign tx_activity_lamp = lamp_reg[sid_pkg::LAMP_TX_BIT];
    assign reflection_alarm_lamp = lamp_reg[sid_pkg::LAMP_REFL_BIT];
    assign fronthaul_port0_lamp_green = lamp_reg[sid_pkg::LAMP_PORT_GREEN_BIT];
    assign fronthaul_port1_lamp_green = lamp_reg[sid_pkg::LAMP_PORT_GREEN_BIT + 1];
    assign fronthaul_port0_lamp_red = lamp_reg[sid_pkg::LAMP_PORT_RED_BIT];
    assign fronthaul_port1_lamp_red = lamp_reg[sid_pkg::LAMP_PORT_RED_BIT + 1];

    ////////////////////////////////////////////////////////////////////////
    // alarm onsets become sticky events
    assign cond_now[sid_pkg::EVT_REPLACE_BIT] = replace_alarm;
    assign cond_now[sid_pkg::EVT_LOCATE_BIT] = locate_alarm;
    assign cond_now[sid_pkg::EVT_REFL_BIT] = |reflection_alarm;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cond_reg <= '0;
        end else begin
            cond_reg <= cond_now;
        end
    end

    // set wins over a write-one clear
    always_comb begin
        evt_next = evt_reg;
        if (reg_wr && reg_addr == sid_pkg::EVT_OFS) begin
            evt_next = evt_reg & ~reg_wdata[sid_pkg::EVT_W-1:0];
        end
        evt_next = evt_next | (cond_now & ~cond_reg);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            evt_reg <= sid_pkg::EVT_RESET;
        end else begin
            evt_reg <= evt_next;
        end
    end

    // level interrupt while an unmasked event is set
    assign irq = |(evt_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // control and mask writes
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg <= sid_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == sid_pkg::CTRL_OFS) begin
            ctrl_reg <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_reg <= sid_pkg::MASK_RESET;
        end else if (reg_wr && reg_addr == sid_pkg::MASK_OFS) begin
            mask_reg <= reg_wdata[sid_pkg::EVT_W-1:0];
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (reg_addr)
            sid_pkg::CTRL_OFS: rdata_next = {30'h0, ctrl_reg};
            sid_pkg::LAMP_OFS: rdata_next = {24'h0, lamp_reg};
            sid_pkg::EVT_OFS: rdata_next = {25'h0, evt_reg};
            sid_pkg::MASK_OFS: rdata_next = {25'h0, mask_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (srst || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

endmodule : sid_status_lamps

`default_nettype wire

// *** tb/sid_lamp_watch.sv ***
`timescale 1ns/100ps
`default_nettype none

module sid_lamp_watch (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // lamp as staff see it
    input wire logic lamp,
    // last lit run, last dark run, current run, in cycles
    output logic [7:0] hi_len,
    output logic [7:0] lo_len,
    output logic [7:0] run
);
    logic prev;

    // run lengths, current run saturates so steady lamps read large
    always_ff @(posedge mclk) begin
        prev <= lamp;
        if (srst) begin
            hi_len <= 8'h00;
            lo_len <= 8'h00;
            run <= 8'h00;
        end else if (lamp != prev) begin
            if (prev) begin
                hi_len <= run;
            end else begin
                lo_len <= run;
            end
            run <= 8'h01;
        end else if (run != 8'hff) begin
            run <= run + 8'h01;
        end
    end
endmodule : sid_lamp_watch

`default_nettype wire

// *** tb/sid_status_checker.sv ***
`timescale 1ns/100ps
`default_nettype none

module sid_status_checker #(
    parameter int unsigned TICK_CYCLES = sid_pkg::FAST_HALF_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // conditions
    input wire logic power_ok,
    input wire logic drive_fault,
    input wire logic unit_fault,
    input wire logic sw_loading,
    input wire logic unit_started,
    input wire logic replace_alarm,
    input wire logic locate_alarm,
    input wire logic [sid_pkg::NUM_REFL-1:0] reflection_alarm,
    input wire logic [sid_pkg::NUM_PORTS-1:0] module_present,
    input wire logic [sid_pkg::NUM_PORTS-1:0] module_powered,
    input wire logic [sid_pkg::NUM_PORTS-1:0] module_fault,
    input wire logic [sid_pkg::NUM_PORTS-1:0] lock_lost,
    input wire logic [sid_pkg::NUM_PORTS-1:0] link_up,
    // lamps and interrupt
    input wire logic health_lamp,
    input wire logic fault_lamp,
    input wire logic tx_activity_lamp,
    input wire logic reflection_alarm_lamp,
    input wire logic fronthaul_port0_lamp_green,
    input wire logic fronthaul_port0_lamp_red,
    input wire logic irq
);
    logic [1:0] ctrl_reg;
    int unsigned hl_run, fl_run, hf_run, sf_run;
    wire ok = (ctrl_reg == 2'h1);
    wire fast_c = ok && power_ok && !drive_fault && (sw_loading || !unit_started);
    wire slow_c = ok && locate_alarm && !replace_alarm;
    wire p0_up = module_present[0] && module_powered[0];

    // shadow of control, lamps follow status only when it reads 1
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg <= sid_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == sid_pkg::CTRL_OFS) begin
            ctrl_reg <= reg_wdata[1:0];
        end
    end

    // lit runs and ages of the blink conditions
    always_ff @(posedge mclk) begin
        hl_run <= health_lamp ? hl_run + 32'd1 : 32'd0;
        fl_run <= fault_lamp ? fl_run + 32'd1 : 32'd0;
        hf_run <= fast_c ? hf_run + 32'd1 : 32'd0;
        sf_run <= slow_c ? sf_run + 32'd1 : 32'd0;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_health_on: assert property (
        ok && power_ok && !drive_fault && !sw_loading && unit_started && unit_fault
        |=> health_lamp) else $error("health lamp not steady");
    a_health_off: assert property (
        ok && (!power_ok || drive_fault) |=> !health_lamp) else $error("health lamp lit");
    a_fast_half: assert property (
        $fell(health_lamp) && hf_run > 3 * TICK_CYCLES |-> hl_run == TICK_CYCLES)
        else $error("fast half period wrong");
    a_fault_on: assert property (
        ok && replace_alarm |=> fault_lamp) else $error("fault lamp not steady");
    a_slow_half: assert property (
        $fell(fault_lamp) && sf_run > 24 * TICK_CYCLES |-> fl_run == 8 * TICK_CYCLES)
        else $error("slow half period wrong");
    a_fault_off: assert property (
        ok && !replace_alarm && !locate_alarm |=> !fault_lamp) else $error("fault lamp lit");
    a_tx_loading: assert property (
        ok && power_ok && sw_loading && !unit_started |=> tx_activity_lamp)
        else $error("activity lamp dark while loading");
    a_refl_follow: assert property (
        ok |=> reflection_alarm_lamp == |$past(reflection_alarm))
        else $error("reflection lamp wrong");
    a_port_green: assert property (
        ok && p0_up && !module_fault[0] && !lock_lost[0] && link_up[0]
        |=> fronthaul_port0_lamp_green && !fronthaul_port0_lamp_red) else $error("not green");
    a_port_red: assert property (
        ok && p0_up && module_fault[0]
        |=> fronthaul_port0_lamp_red && !fronthaul_port0_lamp_green) else $error("not red");
    a_port_dark: assert property (
        ok && !p0_up |=> !fronthaul_port0_lamp_red && !fronthaul_port0_lamp_green)
        else $error("port lamp lit");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read");

    c_irq: cover property ($rose(irq));
    c_fast: cover property ($fell(health_lamp) && hf_run > 3 * TICK_CYCLES);
    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : sid_status_checker

////////////////////////////////////////////////////////////////////////////////
bind sid_status_lamps sid_status_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
    .mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_ok,
    .drive_fault, .unit_fault, .sw_loading, .unit_started, .replace_alarm, .locate_alarm,
    .reflection_alarm, .module_present, .module_powered, .module_fault, .lock_lost,
    .link_up, .health_lamp, .fault_lamp, .tx_activity_lamp, .reflection_alarm_lamp,
    .fronthaul_port0_lamp_green, .fronthaul_port0_lamp_red, .irq
);

`default_nettype wire

// *** tb/sid_status_lamps_test.sv ***
`timescale 1ns/100ps
`default_nettype none

`define SID_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module sid_status_lamps_test;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic power_ok = 1'b1, drive_fault = 1'b0, unit_fault = 1'b0;
    logic sw_loading = 1'b0, unit_started = 1'b1, replace_alarm = 1'b0, locate_alarm = 1'b0;
    logic [3:0] tx_enable = 4'h0;
    logic [1:0] reflection_alarm = 2'h0, module_present = 2'h3, module_powered = 2'h3;
    logic [1:0] module_fault = 2'h0, lock_lost = 2'h0, link_up = 2'h3;
    logic [7:0] lamps;
    logic irq;
    logic [7:0] hi_len [8];
    logic [7:0] lo_len [8];
    logic [7:0] run [8];
    int n_mismatch = 0;
    int checked = 0;

    always #5 mclk = ~mclk;

    sid_status_lamps #(.TICK_CYCLES(4)) dut (
        .mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_ok,
        .drive_fault, .unit_fault, .sw_loading, .unit_started, .replace_alarm, .locate_alarm,
        .tx_enable, .reflection_alarm, .module_present, .module_powered, .module_fault,
        .lock_lost, .link_up, .health_lamp(lamps[0]), .fault_lamp(lamps[1]),
        .tx_activity_lamp(lamps[2]), .reflection_alarm_lamp(lamps[3]),
        .fronthaul_port0_lamp_green(lamps[4]), .fronthaul_port0_lamp_red(lamps[5]),
        .fronthaul_port1_lamp_green(lamps[6]), .fronthaul_port1_lamp_red(lamps[7]), .irq
    );

    // one observer per lamp
    for (genvar i = 0; i < 8; i++) begin : g_watch
        sid_lamp_watch u_watch (.mclk, .srst, .lamp(lamps[i]), .hi_len(hi_len[i]),
            .lo_len(lo_len[i]), .run(run[i]));
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus cycles and shared checks
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `SID_CHK(reg_rdata, exp)
    endtask : chk_reg

    // steady lamps must hold long, blinking ones show exact half periods
    task automatic expect_mode(input int i, input sid_pkg::sid_mode_t m);
        if (m == sid_pkg::MODE_OFF || m == sid_pkg::MODE_ON) begin
            `SID_CHK({lamps[i], run[i] > 8'd69}, {m == sid_pkg::MODE_ON, 1'b1})
        end else begin
            `SID_CHK({hi_len[i], lo_len[i]}, m == sid_pkg::MODE_FAST ? 16'h0404 : 16'h2020)
        end
    endtask : expect_mode

    // apply one status set, let blinks settle, check all eight lamps
    task automatic step(input logic [4:0] h, input logic [1:0] al, input logic [3:0] tx,
        input logic [1:0] rf, input logic [9:0] pt, input logic [15:0] want);
        @(posedge mclk);
        {power_ok, drive_fault, unit_fault, sw_loading, unit_started} <= h;
        {replace_alarm, locate_alarm} <= al;
        tx_enable <= tx;
        reflection_alarm <= rf;
        {module_present, module_powered, module_fault, lock_lost, link_up} <= pt;
        repeat (110) @(posedge mclk);
        #1;
        for (int i = 0; i < 8; i++) begin
            expect_mode(i, sid_pkg::sid_mode_t'(want[2*i+:2]));
        end
    endtask : step

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        repeat (20) @(posedge mclk);
        #1;
        `SID_CHK(lamps[0], 1'b0)
        chk_reg(sid_pkg::CTRL_OFS, 32'h1);
        chk_reg(sid_pkg::EVT_OFS, 32'h0);
        chk_reg(sid_pkg::MASK_OFS, 32'h0);
    endtask : t_reset

    task automatic t_health;
        step(5'b10001, 2'b00, 4'h8, 2'h0, 10'h3c3, 16'h1112);
        step(5'b10001, 2'b00, 4'h0, 2'h0, 10'h3c3, 16'h1122);
        step(5'b10101, 2'b00, 4'h8, 2'h0, 10'h3c3, 16'h1101);
        step(5'b00001, 2'b00, 4'h8, 2'h0, 10'h3c3, 16'h1100);
        step(5'b11001, 2'b00, 4'h0, 2'h0, 10'h3c3, 16'h1120);
        step(5'b10011, 2'b00, 4'h0, 2'h0, 10'h3c3, 16'h1103);
        step(5'b10010, 2'b00, 4'h0, 2'h0, 10'h3c3, 16'h1113);
        step(5'b10000, 2'b00, 4'h0, 2'h0, 10'h3c3, 16'h1103);
    endtask : t_health

    task automatic t_alarms;
        step(5'b10001, 2'b10, 4'h0, 2'h1, 10'h3c3, 16'h1166);
        step(5'b10001, 2'b01, 4'h0, 2'h2, 10'h3c3, 16'h116a);
    endtask : t_alarms

    task automatic t_ports;
        step(5'b10001, 2'b00, 4'h0, 2'h0, 10'h3db, 16'h8422);
        step(5'b10001, 2'b00, 4'h0, 2'h0, 10'h27f, 16'h0022);
        step(5'b10001, 2'b00, 4'h0, 2'h0, 10'h3c2, 16'h1022);
    endtask : t_ports

    task automatic t_regs;
        step(5'b10101, 2'b10, 4'h0, 2'h1, 10'h3e3, 16'h4145);
        chk_reg(sid_pkg::LAMP_OFS, 32'h9b);
        wr(sid_pkg::LAMP_OFS, 32'h0);
        chk_reg(sid_pkg::LAMP_OFS, 32'h9b);
        chk_reg(4'h2, 32'h0);
        wr(sid_pkg::CTRL_OFS, 32'h0);
        chk_reg(sid_pkg::CTRL_OFS, 32'h0);
        `SID_CHK(lamps, 8'h00)
        wr(sid_pkg::CTRL_OFS, 32'h2);
        chk_reg(sid_pkg::CTRL_OFS, 32'h2);
        `SID_CHK(lamps, 8'hff)
        wr(sid_pkg::CTRL_OFS, 32'h1);
    endtask : t_regs

    task automatic t_events;
        @(posedge mclk);
        replace_alarm <= 1'b0;
        wr(sid_pkg::EVT_OFS, 32'h7f);
        wr(sid_pkg::MASK_OFS, 32'h1);
        chk_reg(sid_pkg::EVT_OFS, 32'h0);
        `SID_CHK(irq, 1'b0)
        @(posedge mclk);
        replace_alarm <= 1'b1;
        locate_alarm <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `SID_CHK(irq, 1'b1)
        chk_reg(sid_pkg::EVT_OFS, 32'h3);
        wr(sid_pkg::MASK_OFS, 32'h2);
        wr(sid_pkg::EVT_OFS, 32'h2);
        chk_reg(sid_pkg::EVT_OFS, 32'h1);
        `SID_CHK(irq, 1'b0)
        chk_reg(sid_pkg::MASK_OFS, 32'h2);
    endtask : t_events

    task automatic conclude;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        `SID_CHK(lamps, 8'h00)
        srst <= 1'b0;
        t_reset();
        t_health();
        t_alarms();
        t_ports();
        t_regs();
        t_events();
        conclude();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end
endmodule : sid_status_lamps_test

`default_nettype wire
